// File: core/vic_top.v
/*
  Vectored interrupt controller top: register file on a plain strobe
  port, request flags and enables, per-vector priority, arbitration and
  the request handed to the processor core.
  Assumes one clock (mclk), synchronous active-low reset, peripheral
  events on the same clock, external pins asynchronous.
*/
// The register addresses and strobed register access were left to the implementer.
`timescale 1ns/1ps
`include "vic_regs.vh"

module vic_top #(
  parameter [63:0] IMPL_MASK = 64'hFFFFFFFFFFFFFFFF
) (
  input wire mclk,
  input wire reset_n,
  input wire [15:0] bus_addr,
  input wire [31:0] bus_wdata,
  input wire bus_wr,
  input wire bus_rd,
  output reg [31:0] bus_rdata,
  input wire [63:0] src_event,
  input wire [4:0] ext_pin,
  output reg cpu_irq_req,
  output reg [5:0] cpu_irq_vector,
  output reg [2:0] cpu_irq_level,
  output reg [1:0] cpu_irq_sublevel,
  output reg [31:0] cpu_irq_addr,
  output reg cpu_shadow_sel
);

  // ***********************************************************
  // register state
  // ***********************************************************
  reg [31:0] ctrl_reg;
  reg [31:0] irq_flag_status_low_reg;
  reg [31:0] irq_flag_status_high_reg;
  reg [31:0] irq_enable_low_reg;
  reg [31:0] irq_enable_high_reg;
  reg [31:0] vector_priority_reg [0:10];
  reg [31:0] vector_table_base_reg;
  reg [31:0] vector_table_space_reg;
  reg [31:0] stat_reg;

  // ***********************************************************
  // address decode
  // ***********************************************************
  wire [15:0] base_addr;
  wire [1:0] wr_op;
  wire alias_plain;

  // low nibble selects write alias; reads only at the plain offset
  assign base_addr = bus_addr & ~`VIC_ALIAS_MASK;
  assign wr_op = bus_addr[3:2];
  assign alias_plain = ((bus_addr & `VIC_ALIAS_MASK) == 16'h0000);

  // plain write, clear, set or invert of the written ones
  function [31:0] wop;
    input [31:0] old;
    input [31:0] d;
    input [1:0] op;
    begin
      case (op)
        `VIC_OP_WR: wop = d;
        `VIC_OP_CLR: wop = old & ~d;
        `VIC_OP_SET: wop = old | d;
        `VIC_OP_INV: wop = old ^ d;
        default: wop = old;
      endcase
    end
  endfunction

  wire wr_ok;
  wire hit_ctrl;
  wire hit_flag_lo;
  wire hit_flag_hi;
  wire hit_en_lo;
  wire hit_en_hi;
  wire hit_base;
  wire hit_space;

  // byte lanes 1:0 must be zero for a write to count
  assign wr_ok = bus_wr && (bus_addr[1:0] == 2'h0);
  assign hit_ctrl = wr_ok && (base_addr == `VIC_OFF_CTRL);
  assign hit_flag_lo = wr_ok && (base_addr == `VIC_OFF_FLAG_LO);
  assign hit_flag_hi = wr_ok && (base_addr == `VIC_OFF_FLAG_HI);
  assign hit_en_lo = wr_ok && (base_addr == `VIC_OFF_EN_LO);
  assign hit_en_hi = wr_ok && (base_addr == `VIC_OFF_EN_HI);
  assign hit_base = wr_ok && (base_addr == `VIC_OFF_VT_BASE);
  assign hit_space = wr_ok && (base_addr == `VIC_OFF_VT_SPACE);

  // ***********************************************************
  // external inputs
  // ***********************************************************
  wire [4:0] ext_evt;
  genvar g;

  generate
    for (g = 0; g < `VIC_NUM_EXT; g = g + 1) begin : ext_gen
      vic_ext_edge u_edge (
        .mclk(mclk),
        .reset_n(reset_n),
        .pin(ext_pin[g]),
        .rise_sel(ctrl_reg[g]),
        .edge_evt(ext_evt[g])
      );
    end
  endgenerate

  // ***********************************************************
  // hardware set terms
  // ***********************************************************
  reg [63:0] hw_set;

  always @* begin
    hw_set = src_event;
    hw_set[`VIC_IRQ_EXT0] = src_event[`VIC_IRQ_EXT0] | ext_evt[0];
    hw_set[`VIC_IRQ_EXT1] = src_event[`VIC_IRQ_EXT1] | ext_evt[1];
    hw_set[`VIC_IRQ_EXT2] = src_event[`VIC_IRQ_EXT2] | ext_evt[2];
    hw_set[`VIC_IRQ_EXT3] = src_event[`VIC_IRQ_EXT3] | ext_evt[3];
    hw_set[`VIC_IRQ_EXT4] = src_event[`VIC_IRQ_EXT4] | ext_evt[4];
  end

  // ***********************************************************
  // flag and enable next values
  // ***********************************************************
  reg [31:0] flag_lo_next;
  reg [31:0] flag_hi_next;
  reg [31:0] en_lo_next;
  reg [31:0] en_hi_next;

  always @* begin
    flag_lo_next = irq_flag_status_low_reg;
    flag_hi_next = irq_flag_status_high_reg;
    en_lo_next = irq_enable_low_reg;
    en_hi_next = irq_enable_high_reg;
    if (hit_flag_lo) begin
      flag_lo_next = wop(irq_flag_status_low_reg, bus_wdata, wr_op);
    end
    if (hit_flag_hi) begin
      flag_hi_next = wop(irq_flag_status_high_reg, bus_wdata, wr_op);
    end
    if (hit_en_lo) begin
      en_lo_next = wop(irq_enable_low_reg, bus_wdata, wr_op);
    end
    if (hit_en_hi) begin
      en_hi_next = wop(irq_enable_high_reg, bus_wdata, wr_op);
    end
    // request n at word n/32, bit n%32
    flag_lo_next = (flag_lo_next | hw_set[31:0]) & IMPL_MASK[31:0];
    flag_hi_next = (flag_hi_next | hw_set[63:32]) & IMPL_MASK[63:32];
    en_lo_next = en_lo_next & IMPL_MASK[31:0];
    en_hi_next = en_hi_next & IMPL_MASK[63:32];
  end

  // ***********************************************************
  // register writes
  // ***********************************************************
  integer k;

  always @(posedge mclk) begin
    if (!reset_n) begin
      ctrl_reg <= `VIC_RST_WORD;
      irq_flag_status_low_reg <= `VIC_RST_WORD;
      irq_flag_status_high_reg <= `VIC_RST_WORD;
      irq_enable_low_reg <= `VIC_RST_WORD;
      irq_enable_high_reg <= `VIC_RST_WORD;
      vector_table_base_reg <= `VIC_RST_WORD;
      vector_table_space_reg <= `VIC_RST_WORD;
      for (k = 0; k < `VIC_NUM_IPC; k = k + 1) begin
        vector_priority_reg[k] <= `VIC_RST_WORD;
      end
    end else begin
      irq_flag_status_low_reg <= flag_lo_next;
      irq_flag_status_high_reg <= flag_hi_next;
      irq_enable_low_reg <= en_lo_next;
      irq_enable_high_reg <= en_hi_next;
      if (hit_ctrl) begin
        ctrl_reg <= wop(ctrl_reg, bus_wdata, wr_op) & `VIC_CTRL_MASK;
      end
      if (hit_base) begin
        vector_table_base_reg <= wop(vector_table_base_reg, bus_wdata, wr_op);
      end
      if (hit_space) begin
        vector_table_space_reg <= wop(vector_table_space_reg, bus_wdata, wr_op)
                                  & `VIC_SPACE_MASK;
      end
      for (k = 0; k < `VIC_NUM_IPC; k = k + 1) begin
        if (wr_ok && base_addr == `VIC_OFF_VECTOR_PRIORITY_0 + k * `VIC_IPC_STRIDE) begin
          vector_priority_reg[k] <= wop(vector_priority_reg[k], bus_wdata, wr_op)
                                    & `VIC_IPC_MASK;
        end
      end
    end
  end

  // ***********************************************************
  // vector pending
  // ***********************************************************
  wire [43:0] vec_pend;

  vic_vec_pend u_pend (
    .flags({irq_flag_status_high_reg, irq_flag_status_low_reg}),
    .enables({irq_enable_high_reg, irq_enable_low_reg}),
    .vec_pend(vec_pend)
  );

  // ***********************************************************
  // arbitration
  // ***********************************************************
  reg found;
  reg [4:0] best_key;
  reg [5:0] best_vec;
  reg [31:0] lane;
  reg [4:0] key;
  integer v;

  // ascending scan with strict compare keeps the lowest vector on ties
  // pick highest pending
  always @* begin
    found = 1'b0;
    best_key = 5'h00;
    best_vec = 6'h00;
    lane = `VIC_RST_WORD;
    key = 5'h00;
    for (v = 0; v < `VIC_NUM_VEC; v = v + 1) begin
      lane = vector_priority_reg[v / 4] >> ((v % 4) * `VIC_IPC_LANE_W);
      key = {lane[`VIC_PRI_HI:`VIC_PRI_LO], lane[`VIC_SUB_HI:`VIC_SUB_LO]};
      if (vec_pend[v] && (lane[`VIC_PRI_HI:`VIC_PRI_LO] != 3'h0) &&
          (!found || key > best_key)) begin
        found = 1'b1;
        best_key = key;
        best_vec = v[5:0];
      end
    end
  end

  // ***********************************************************
  // dispatch address
  // ***********************************************************
  wire [15:0] vec_offset;
  wire [31:0] disp_addr;
  wire mvec;

  assign mvec = ctrl_reg[`VIC_CTRL_MVEC];
  // 6-bit vector times 10-bit spacing fits 16 bits
  assign vec_offset = {10'h000, best_vec} * vector_table_space_reg[15:0];
  assign disp_addr = mvec ? vector_table_base_reg + {16'h0000, vec_offset}
                          : vector_table_base_reg;

  // ***********************************************************
  // request to the core
  // ***********************************************************
  // outputs are registered, so the core sees the winner one cycle late
  always @(posedge mclk) begin
    if (!reset_n) begin
      cpu_irq_req <= 1'b0;
      cpu_irq_vector <= 6'h00;
      cpu_irq_level <= 3'h0;
      cpu_irq_sublevel <= 2'h0;
      cpu_irq_addr <= `VIC_RST_WORD;
      cpu_shadow_sel <= 1'b0;
      stat_reg <= `VIC_RST_WORD;
    end else begin
      cpu_irq_req <= found;
      cpu_irq_vector <= found ? best_vec : 6'h00;
      cpu_irq_level <= found ? best_key[4:2] : 3'h0;
      cpu_irq_sublevel <= found ? best_key[1:0] : 2'h0;
      cpu_irq_addr <= disp_addr;
      cpu_shadow_sel <= 1'b0;
      stat_reg <= found ? ({21'h000000, best_key[4:2], 8'h00} |
                           {26'h0000000, best_vec}) : `VIC_RST_WORD;
    end
  end

  // ***********************************************************
  // read port
  // ***********************************************************
  reg [31:0] rd_val;
  // own loop index, the write process already drives k
  integer r;

  // unmapped and alias addresses read as zero
  always @* begin
    rd_val = `VIC_RST_WORD;
    if (alias_plain) begin
      case (bus_addr)
        `VIC_OFF_CTRL: rd_val = ctrl_reg;
        `VIC_OFF_STAT: rd_val = stat_reg;
        `VIC_OFF_FLAG_LO: rd_val = irq_flag_status_low_reg;
        `VIC_OFF_FLAG_HI: rd_val = irq_flag_status_high_reg;
        `VIC_OFF_EN_LO: rd_val = irq_enable_low_reg;
        `VIC_OFF_EN_HI: rd_val = irq_enable_high_reg;
        `VIC_OFF_VT_BASE: rd_val = vector_table_base_reg;
        `VIC_OFF_VT_SPACE: rd_val = vector_table_space_reg;
        default: rd_val = `VIC_RST_WORD;
      endcase
      for (r = 0; r < `VIC_NUM_IPC; r = r + 1) begin
        if (bus_addr == `VIC_OFF_VECTOR_PRIORITY_0 + r * `VIC_IPC_STRIDE) begin
          rd_val = vector_priority_reg[r];
        end
      end
    end
  end

  // data stands only in the cycle after the strobe
  always @(posedge mclk) begin
    if (!reset_n) begin
      bus_rdata <= `VIC_RST_WORD;
    end else begin
      bus_rdata <= bus_rd ? rd_val : `VIC_RST_WORD;
    end
  end

endmodule

// File: pkg/vic_regs.vh
/*
  Register map, field positions and sizes of the vectored interrupt
  controller. Definitions only; included by bare name from core files.
*/
`ifndef VIC_REGS_VH
`define VIC_REGS_VH

// ***********************************************************
// sizes
// ***********************************************************
`define VIC_ADDR_W 16
`define VIC_NUM_SRC 64
`define VIC_NUM_VEC 44
`define VIC_NUM_IPC 11
`define VIC_NUM_EXT 5

// ***********************************************************
// register offsets (byte addresses, word aligned)
// ***********************************************************
`define VIC_OFF_CTRL 16'h1000
`define VIC_OFF_STAT 16'h1010
`define VIC_OFF_FLAG_LO 16'h1030
`define VIC_OFF_FLAG_HI 16'h1040
`define VIC_OFF_EN_LO 16'h1060
`define VIC_OFF_EN_HI 16'h1070
`define VIC_OFF_VECTOR_PRIORITY_0 16'h1090
`define VIC_IPC_STRIDE 16'h0010
`define VIC_OFF_VT_BASE 16'h1140
`define VIC_OFF_VT_SPACE 16'h1150

// write alias op in address bits 3:2: plain, clear, set, invert
`define VIC_OP_WR 2'h0
`define VIC_OP_CLR 2'h1
`define VIC_OP_SET 2'h2
`define VIC_OP_INV 2'h3
`define VIC_ALIAS_MASK 16'h000F

// ***********************************************************
// fields
// ***********************************************************
`define VIC_CTRL_MVEC 12
`define VIC_CTRL_MASK 32'h0000171F
`define VIC_STAT_LVL_LO 8
`define VIC_IPC_MASK 32'h1F1F1F1F
`define VIC_IPC_LANE_W 8
`define VIC_PRI_HI 4
`define VIC_PRI_LO 2
`define VIC_SUB_HI 1
`define VIC_SUB_LO 0
`define VIC_SPACE_MASK 32'h000003FF
`define VIC_RST_WORD 32'h00000000

// external inputs sit on these request numbers
`define VIC_IRQ_EXT0 3
`define VIC_IRQ_EXT1 8
`define VIC_IRQ_EXT2 13
`define VIC_IRQ_EXT3 18
`define VIC_IRQ_EXT4 23

`endif

// File: core/vic_ext_edge.v
/*
  One external interrupt input: three-stage synchroniser, change taken
  once stages two and three agree, one-cycle pulse on the selected edge.
  Assumes the pin is asynchronous to mclk and held for three cycles.
*/
`timescale 1ns/1ps
module vic_ext_edge (
  input wire mclk,
  input wire reset_n,
  input wire pin,
  input wire rise_sel,
  output reg edge_evt
);

  reg sync1_reg;
  reg sync2_reg;
  reg sync3_reg;
  reg level_reg;

  // ***********************************************************
  // synchroniser and edge detect
  // ***********************************************************
  // stage one feeds stage two only, to keep metastability contained
  always @(posedge mclk) begin
    if (!reset_n) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      sync3_reg <= 1'b0;
      level_reg <= 1'b0;
      edge_evt <= 1'b0;
    end else begin
      sync1_reg <= pin;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      edge_evt <= 1'b0;
      if (sync2_reg == sync3_reg && sync3_reg != level_reg) begin
        level_reg <= sync3_reg;
        edge_evt <= (sync3_reg == rise_sel);
      end
    end
  end

endmodule

// File: core/vic_vec_pend.v
/*
  Folds the 64 request flags onto the 44 vectors: a vector is pending
  when any source mapped to it is flagged and enabled. Pure logic.
*/
`timescale 1ns/1ps
`include "vic_regs.vh"
module vic_vec_pend (
  input wire [63:0] flags,
  input wire [63:0] enables,
  output reg [43:0] vec_pend
);

  // fixed request-to-vector table; shared vectors group sources
  function [5:0] vec_of;
    input integer i;
    integer v;
    begin
      if (i <= 5) v = i;
      else if (i == 6) v = 5;
      else if (i <= 9) v = i - 1;
      else if (i <= 11) v = 9;
      else if (i <= 14) v = i - 2;
      else if (i <= 16) v = 13;
      else if (i <= 19) v = i - 3;
      else if (i <= 21) v = 17;
      else if (i <= 24) v = i - 4;
      else if (i <= 26) v = 21;
      else if (i <= 35) v = i - 5;
      else if (i <= 38) v = 31;
      else if (i <= 41) v = 32;
      else if (i <= 44) v = 33;
      else if (i <= 47) v = 34;
      else if (i <= 49) v = 35;
      else if (i <= 52) v = 36;
      else if (i <= 55) v = 37;
      else if (i <= 58) v = 38;
      else v = i - 20;
      vec_of = v[5:0];
    end
  endfunction

  integer i;

  // ***********************************************************
  // vector pending
  // ***********************************************************
  // sources share vectors
  always @* begin
    vec_pend = {`VIC_NUM_VEC{1'b0}};
    for (i = 0; i < `VIC_NUM_SRC; i = i + 1) begin
      if (flags[i] && enables[i]) begin
        vec_pend[vec_of(i)] = 1'b1;
      end
    end
  end

endmodule

// File: tb/vic_properties.sv
/*
  Concurrent checks on the controller top ports.
  Assumes plain writes to control, table base and spacing.
*/
`timescale 1ns/1ps
`include "vic_regs.vh"
module vic_properties (
  input wire mclk,
  input wire reset_n,
  input wire [15:0] bus_addr,
  input wire [31:0] bus_wdata,
  input wire bus_wr,
  input wire bus_rd,
  input wire [31:0] bus_rdata,
  input wire [63:0] src_event,
  input wire [4:0] ext_pin,
  input wire cpu_irq_req,
  input wire [5:0] cpu_irq_vector,
  input wire [2:0] cpu_irq_level,
  input wire [31:0] cpu_irq_addr,
  input wire cpu_shadow_sel
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  reg mvec_reg;
  reg [31:0] base_reg;
  reg [31:0] space_reg;
  // ***********************************************************
  // shadow copy of dispatch settings
  // ***********************************************************
  // only plain writes are followed, aliases would desync this copy
  always @(posedge mclk) begin
    if (!reset_n) begin
      mvec_reg <= 1'b0;
      base_reg <= 32'h0;
      space_reg <= 32'h0;
    end else if (bus_wr) begin
      if (bus_addr == `VIC_OFF_CTRL) mvec_reg <= bus_wdata[`VIC_CTRL_MVEC];
      if (bus_addr == `VIC_OFF_VT_BASE) base_reg <= bus_wdata;
      if (bus_addr == `VIC_OFF_VT_SPACE) space_reg <= bus_wdata & `VIC_SPACE_MASK;
    end
  end
  a_shadow_never: assert property (cpu_shadow_sel == 1'b0)
    else $error("shadow select raised");
  a_rdata_idle: assert property (!$past(bus_rd) |-> bus_rdata == 32'h0)
    else $error("read data outside read slot");
  a_status_read: assert property (bus_rd && bus_addr == `VIC_OFF_STAT |=>
    bus_rdata == {21'h0, $past(cpu_irq_level), 2'h0, $past(cpu_irq_vector)})
    else $error("status read wrong");
  a_req_level: assert property (cpu_irq_req |-> cpu_irq_level != 3'h0)
    else $error("request at priority zero");
  a_idle_zero: assert property (!cpu_irq_req |-> cpu_irq_vector == 6'h0 &&
    cpu_irq_level == 3'h0) else $error("winner shown without request");
  a_vec_range: assert property (cpu_irq_vector <= 6'h2B)
    else $error("vector out of range");
  a_addr_form: assert property (cpu_irq_req && !$past(bus_wr) |-> cpu_irq_addr ==
    (mvec_reg ? base_reg + {26'h0, cpu_irq_vector} * space_reg : base_reg))
    else $error("dispatch address wrong");
  a_req_fall: assert property ($fell(cpu_irq_req) |-> $past(bus_wr) || $past(bus_wr, 2))
    else $error("request dropped without write");
  a_rise_cause: assert property ($rose(cpu_irq_req) |-> $past(bus_wr) ||
    $past(bus_wr, 2) || (|$past(src_event, 2)) || $past(ext_pin, 2) != $past(ext_pin, 10))
    else $error("request without cause");
endmodule
bind vic_top vic_properties u_props (.mclk(mclk), .reset_n(reset_n),
  .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
  .bus_rdata(bus_rdata), .src_event(src_event), .ext_pin(ext_pin),
  .cpu_irq_req(cpu_irq_req), .cpu_irq_vector(cpu_irq_vector),
  .cpu_irq_level(cpu_irq_level), .cpu_irq_addr(cpu_irq_addr),
  .cpu_shadow_sel(cpu_shadow_sel));

// File: tb/vic_core_model.sv
/*
  Processor core stand-in: latches the request it would take.
  Assumes registered request outputs on mclk.
*/
`timescale 1ns/1ps
module vic_core_model (
  input wire mclk,
  input wire reset_n,
  input wire irq_req,
  input wire [5:0] irq_vector,
  input wire [31:0] irq_addr,
  output reg [5:0] taken_vec,
  output reg [31:0] taken_addr
);
  // take whatever is offered each cycle, no acknowledge exists
  always @(posedge mclk) begin
    if (!reset_n) begin
      taken_vec <= 6'h0;
      taken_addr <= 32'h0;
    end else if (irq_req) begin
      taken_vec <= irq_vector;
      taken_addr <= irq_addr;
    end
  end
endmodule

// File: tb/vic_top_tb.sv
/*
  Self-checking bench for the controller, reference model in arrays.
  Assumes the register bus contract and a 125 MHz mclk.
*/
`timescale 1ns/1ps
`include "vic_regs.vh"
module vic_top_tb;
  localparam [63:0] IMPL = 64'hBFFFFFFFFFFFFFFF;
  reg mclk = 1'b0;
  reg reset_n = 1'b0;
  reg [15:0] bus_addr = 16'h0;
  reg [31:0] bus_wdata = 32'h0;
  reg bus_wr = 1'b0;
  reg bus_rd = 1'b0;
  reg [63:0] src_event = 64'h0;
  reg [4:0] ext_pin = 5'h0;
  wire [31:0] bus_rdata;
  wire cpu_irq_req;
  wire [5:0] cpu_irq_vector;
  wire [2:0] cpu_irq_level;
  wire [1:0] cpu_irq_sublevel;
  wire [31:0] cpu_irq_addr;
  wire [5:0] taken_vec;
  integer n_errors = 0;
  integer checks = 0;
  integer seed = 25982;
  integer k;
  integer it;
  reg [63:0] fl;
  reg [63:0] en;
  reg [31:0] ipc [0:10];
  reg [31:0] ctrl;
  reg [31:0] base;
  reg [31:0] space;
  reg [31:0] rv;
  integer vt [0:63] = '{0,1,2,3,4,5,5,6,7,8,9,9,10,11,12,13,13,14,15,16,17,17,18,19,20,21,
    21,22,23,24,25,26,27,28,29,30,31,31,31,32,32,32,33,33,33,34,34,34,35,35,36,36,36,37,37,
    37,38,38,38,39,40,41,42,43};
  reg [15:0] ta [0:5] = '{`VIC_OFF_CTRL, `VIC_OFF_VT_BASE, `VIC_OFF_VT_SPACE,
    `VIC_OFF_EN_LO, `VIC_OFF_EN_HI, `VIC_OFF_STAT};
  reg [31:0] tm [0:5] = '{`VIC_CTRL_MASK, 32'hFFFFFFFF, `VIC_SPACE_MASK,
    IMPL[31:0], IMPL[63:32], 32'h0};
  always #4 mclk = ~mclk;
  vic_top #(.IMPL_MASK(IMPL)) dut (.mclk(mclk), .reset_n(reset_n), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
    .src_event(src_event), .ext_pin(ext_pin), .cpu_irq_req(cpu_irq_req),
    .cpu_irq_vector(cpu_irq_vector), .cpu_irq_level(cpu_irq_level),
    .cpu_irq_sublevel(cpu_irq_sublevel), .cpu_irq_addr(cpu_irq_addr),
    .cpu_shadow_sel());
  vic_core_model core (.mclk(mclk), .reset_n(reset_n), .irq_req(cpu_irq_req),
    .irq_vector(cpu_irq_vector), .irq_addr(cpu_irq_addr), .taken_vec(taken_vec),
    .taken_addr());
  // ***********************************************************
  // bus and compare helpers
  // ***********************************************************
  task chk(input string w, input [31:0] e, input [31:0] g);
    checks = checks + 1;
    if (g !== e) begin
      n_errors = n_errors + 1;
      $display("CHECK FAILED %s expected %h seen %h", w, e, g);
    end
  endtask
  task wr(input [15:0] a, input [31:0] d);
    @(posedge mclk);
    bus_addr <= a;
    bus_wdata <= d;
    bus_wr <= 1'b1;
    @(posedge mclk);
    bus_wr <= 1'b0;
  endtask
  // data stands only in the cycle after the strobe
  task rchk(input string w, input [15:0] a, input [31:0] e);
    @(posedge mclk);
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge mclk);
    bus_rd <= 1'b0;
    @(negedge mclk);
    chk(w, e, bus_rdata);
  endtask
  // reference arbitration, ties fall to the lowest vector
  task cmp_out;
    integer j, v, p, s, bv, bp, bs;
    bp = 0;
    bs = 0;
    bv = 0;
    for (j = 0; j < 64; j = j + 1) begin
      v = vt[j];
      p = (ipc[v / 4] >> (8 * (v % 4) + 2)) & 7;
      s = (ipc[v / 4] >> (8 * (v % 4))) & 3;
      if (fl[j] && en[j] && p > 0 && (p > bp || (p == bp && (s > bs || (s == bs && v < bv)))))
      begin
        bp = p;
        bs = s;
        bv = v;
      end
    end
    chk("req", bp > 0, cpu_irq_req);
    chk("vector", bv, cpu_irq_vector);
    chk("level", bp, cpu_irq_level);
    if (bp > 0) begin
      chk("sublevel", bs, cpu_irq_sublevel);
      chk("addr", ctrl[12] ? base + bv * space : base, cpu_irq_addr);
      chk("core vector", bv, taken_vec);
    end
    rchk("status", `VIC_OFF_STAT, (bp << 8) | bv);
  endtask
  task finish_test;
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge mclk);
    n_errors = n_errors + 1;
    $display("CHECK FAILED watchdog expected end seen hang");
    finish_test;
  end
  // ***********************************************************
  // main sequence
  // ***********************************************************
  initial begin
    repeat (6) @(posedge mclk);
    reset_n <= 1'b1;
    for (k = 0; k < 11; k = k + 1) rchk("prio reset", `VIC_OFF_VECTOR_PRIORITY_0 + 16 * k, 0);
    for (k = 0; k < 6; k = k + 1) begin
      rchk("reset", ta[k], 0);
      wr(ta[k], 32'hFFFFFFFF);
      rchk("mask", ta[k], tm[k]);
      wr(ta[k], 32'h0);
    end
    wr(16'h2000, 32'hFFFFFFFF);
    rchk("unmapped", 16'h2000, 0);
    wr(`VIC_OFF_EN_LO, 32'h000000F0);
    wr(`VIC_OFF_EN_LO + 16'h8, 32'h0000000F);
    rchk("set alias", `VIC_OFF_EN_LO, 32'h000000FF);
    wr(`VIC_OFF_EN_LO + 16'h4, 32'h00000030);
    rchk("clr alias", `VIC_OFF_EN_LO, 32'h000000CF);
    wr(`VIC_OFF_EN_LO + 16'hC, 32'h000000FF);
    rchk("inv alias", `VIC_OFF_EN_LO, 32'h00000030);
    for (it = 0; it < 24; it = it + 1) begin
      for (k = 0; k < 11; k = k + 1) begin
        ipc[k] = $random(seed) & `VIC_IPC_MASK;
        wr(`VIC_OFF_VECTOR_PRIORITY_0 + 16 * k, ipc[k]);
      end
      en = {$random(seed), $random(seed)} & IMPL;
      fl = {$random(seed), $random(seed)} & {$random(seed), $random(seed)} & IMPL;
      ctrl = ($random(seed) & 1) << 12;
      base = $random(seed);
      space = $random(seed) & `VIC_SPACE_MASK;
      wr(`VIC_OFF_EN_LO, en[31:0]);
      wr(`VIC_OFF_EN_HI, en[63:32]);
      wr(`VIC_OFF_FLAG_LO, fl[31:0]);
      wr(`VIC_OFF_FLAG_HI, fl[63:32]);
      wr(`VIC_OFF_CTRL, ctrl);
      wr(`VIC_OFF_VT_BASE, base);
      wr(`VIC_OFF_VT_SPACE, space);
      k = $random(seed) & 63;
      src_event <= 64'h1 << k;
      @(posedge mclk);
      src_event <= 64'h0;
      fl[k] = IMPL[k];
      repeat (2) @(posedge mclk);
      @(negedge mclk);
      cmp_out;
      rchk("flags lo", `VIC_OFF_FLAG_LO, fl[31:0]);
      rchk("flags hi", `VIC_OFF_FLAG_HI, fl[63:32]);
    end
    @(posedge mclk);
    src_event <= 64'h10000000;
    wr(`VIC_OFF_FLAG_LO, 32'h0);
    wr(`VIC_OFF_FLAG_HI, 32'h0);
    rchk("held source", `VIC_OFF_FLAG_LO, 32'h10000000);
    @(posedge mclk);
    src_event <= 64'h0;
    wr(`VIC_OFF_FLAG_LO + 16'h4, 32'h10000000);
    rchk("cleared", `VIC_OFF_FLAG_LO, 0);
    ctrl = 32'h15;
    wr(`VIC_OFF_CTRL, ctrl);
    ext_pin <= 5'h1F;
    repeat (12) @(posedge mclk);
    rchk("rising pins", `VIC_OFF_FLAG_LO, 32'h00802008);
    @(posedge mclk);
    ext_pin <= 5'h0;
    repeat (12) @(posedge mclk);
    rchk("falling pins", `VIC_OFF_FLAG_LO, 32'h00842108);
    fl = 64'h0000000000842108;
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    cmp_out;
    fl = 64'h0;
    wr(`VIC_OFF_FLAG_LO, 32'h0);
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    cmp_out;
    finish_test;
  end
endmodule
